//--- rtl/usfrb_defs.vh
// constants for the serial frame and receive buffer block
`ifndef USFRB_DEFS_VH
`define USFRB_DEFS_VH
`define USFRB_SIZE_5 3'h0
`define USFRB_SIZE_9 3'h7
`define USFRB_PAR_NONE 2'h0
`define USFRB_PAR_EVEN 2'h2
`define USFRB_PAR_ODD 2'h3
`define USFRB_DIV_DEF 16'h0010
`define USFRB_FIFO_DEPTH 2
`endif

//--- rtl/usfrb_usart.v
// frame transmitter, receiver and two-entry receive buffer
`include "usfrb_defs.vh"
`default_nettype none
module usfrb_usart #(
    parameter [15:0] BIT_DIV = `USFRB_DIV_DEF
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // configuration
    input wire syncMode,
    input wire syncClockPolarity,
    input wire [2:0] characterSizeCode,
    input wire [1:0] parityMode,
    input wire twoStopBits,
    // transmit request
    input wire txValid,
    input wire [8:0] txData,
    output reg txReady,
    // receive buffer read
    input wire dataRead,
    output reg rxValid,
    output reg [7:0] serialDataReg,
    output reg receivedNinthBit,
    output reg framingErrorFlag,
    output reg dataOverrunFlag,
    output reg parityErrorFlag,
    // serial lines
    input wire rxdPin,
    input wire syncSerialClock,
    output reg txdPin
);
    localparam S_IDLE = 2'h0;
    localparam S_BITS = 2'h1;
    function par9;
        input [8:0] d;
        input [3:0] n;
        input odd;
        integer i;
        begin
            par9 = odd;
            for (i = 0; i < 9; i = i + 1)
                if (i < n)
                    par9 = par9 ^ d[i];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    reg [1:0] rxSync_r;
    reg [1:0] ckSync_r;
    reg ckPrev_r;
    reg rxPrev_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxSync_r <= 2'h3;
            ckSync_r <= 2'h0;
            ckPrev_r <= 1'b0;
            rxPrev_r <= 1'b1;
        end
        else
        begin
            rxSync_r <= {rxSync_r[0], rxdPin};
            ckSync_r <= {ckSync_r[0], syncSerialClock};
            ckPrev_r <= ckSync_r[1];
            rxPrev_r <= rxSync_r[1];
        end
    end
    wire rxIn = rxSync_r[1];
    wire ckRise = ckSync_r[1] & ~ckPrev_r;
    wire ckFall = ~ckSync_r[1] & ckPrev_r;
    wire sampleEdge = syncClockPolarity ? ckFall : ckRise;
    wire changeEdge = syncClockPolarity ? ckRise : ckFall;

    wire [3:0] nData = {1'b0, characterSizeCode[2] ?
        3'h4 : characterSizeCode} + 4'h5;
    wire parOn = parityMode[1];
    wire parOdd = parityMode[0];
    wire [3:0] nBits = nData + {3'h0, parOn} + {3'h0, twoStopBits} + 4'h2;

    ////////////////////////////////////////////////////////////////////////
    // async bit timing
    reg [15:0] txDiv_r;
    wire txTick = syncMode ? changeEdge : (txDiv_r == 16'h0000);
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            txDiv_r <= 16'h0000;
        else if (txDiv_r == 16'h0000)
            txDiv_r <= BIT_DIV - 16'h0001;
        else
            txDiv_r <= txDiv_r - 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    reg [1:0] txState_r;
    reg [11:0] txShift_r;
    reg [3:0] txCnt_r;
    reg txLoad_r;
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txState_r <= S_IDLE;
            txShift_r <= 12'hfff;
            txCnt_r <= 4'h0;
            txdPin <= 1'b1;
            txReady <= 1'b1;
            txLoad_r <= 1'b0;
        end
        else
        begin
            case (txState_r)
                S_IDLE:
                begin
                    txdPin <= 1'b1;
                    if (txValid && txReady)
                    begin
                        txReady <= 1'b0;
                        txLoad_r <= 1'b1;
                    end
                    if (txLoad_r && txTick)
                    begin
                        txLoad_r <= 1'b0;
                        txShift_r <= ({12'hfff} << (nData + {3'h0, parOn}))
                            | ({11'h0, parOn &
                               par9(txData, nData, parOdd)} << nData)
                            | ({3'h0, txData} &
                               ~(12'hfff << nData));
                        txdPin <= 1'b0;
                        txCnt_r <= nBits - 4'h1;
                        txState_r <= S_BITS;
                    end
                end
                S_BITS:
                begin
                    if (txTick)
                    begin
                        txdPin <= txShift_r[0];
                        txShift_r <= {1'b1, txShift_r[11:1]};
                        txCnt_r <= txCnt_r - 4'h1;
                        if (txCnt_r == 4'h1)
                        begin
                            txState_r <= S_IDLE;
                            txReady <= 1'b1;
                        end
                    end
                end
                default:
                    txState_r <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    reg [1:0] rxState_r;
    reg [15:0] rxDiv_r;
    reg [3:0] rxCnt_r;
    reg [9:0] rxShift_r;
    reg rxPar_r;
    reg rxPush_r;
    reg [11:0] rxWord_r;
    wire rxTick = syncMode ? sampleEdge : (rxDiv_r == 16'h0000);
    wire [3:0] nBody = nData + {3'h0, parOn};
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxState_r <= S_IDLE;
            rxDiv_r <= 16'h0000;
            rxCnt_r <= 4'h0;
            rxShift_r <= 10'h000;
            rxPar_r <= 1'b0;
            rxPush_r <= 1'b0;
            rxWord_r <= 12'h000;
        end
        else
        begin
            rxPush_r <= 1'b0;
            if (rxDiv_r != 16'h0000)
                rxDiv_r <= rxDiv_r - 16'h0001;
            case (rxState_r)
                S_IDLE:
                    if ((syncMode && sampleEdge && !rxIn) ||
                        (!syncMode && !rxIn && rxPrev_r))
                    begin
                        rxDiv_r <= BIT_DIV + (BIT_DIV >> 1) - 16'h0001;
                        rxCnt_r <= 4'h0;
                        rxPar_r <= parOdd;
                        rxState_r <= S_BITS;
                    end
                S_BITS:
                    if (rxTick)
                    begin
                        rxDiv_r <= BIT_DIV - 16'h0001;
                        rxCnt_r <= rxCnt_r + 4'h1;
                        if (rxCnt_r < nBody)
                        begin
                            rxShift_r[rxCnt_r] <= rxIn;
                            rxPar_r <= rxPar_r ^ rxIn;
                        end
                        else
                        begin
                            rxWord_r <= {!rxIn, parOn & rxPar_r, 1'b0,
                                rxShift_r[8:0] & ~(9'h1ff << nData)};
                            rxPush_r <= 1'b1;
                            rxState_r <= S_IDLE;
                        end
                    end
                default:
                    rxState_r <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-entry receive buffer
    reg [11:0] fifo_r [0:`USFRB_FIFO_DEPTH-1];
    reg wrPtr_r;
    reg rdPtr_r;
    reg [1:0] count_r;
    reg overrun_r;
    wire pop = dataRead && count_r != 2'h0;
    wire push = rxPush_r && (count_r != 2'h2 || pop);
    wire [1:0] countNxt = count_r + {1'b0, push} - {1'b0, pop};
    wire rdNxt = rdPtr_r ^ pop;
    wire [11:0] head = fifo_r[rdNxt];
    wire [11:0] shown = count_r[1] ? head :
        {rxWord_r[11:10], overrun_r, rxWord_r[8:0]};
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fifo_r[0] <= 12'h000;
            fifo_r[1] <= 12'h000;
            wrPtr_r <= 1'b0;
            rdPtr_r <= 1'b0;
            count_r <= 2'h0;
            overrun_r <= 1'b0;
            rxValid <= 1'b0;
            serialDataReg <= 8'h00;
            receivedNinthBit <= 1'b0;
            framingErrorFlag <= 1'b0;
            parityErrorFlag <= 1'b0;
            dataOverrunFlag <= 1'b0;
        end
        else
        begin
            if (rxPush_r && !push)
                overrun_r <= 1'b1;
            if (push)
            begin
                fifo_r[wrPtr_r] <= {rxWord_r[11:10], overrun_r,
                    rxWord_r[8:0]};
                overrun_r <= 1'b0;
                wrPtr_r <= ~wrPtr_r;
            end
            rdPtr_r <= rdNxt;
            count_r <= countNxt;
            rxValid <= countNxt != 2'h0;
            // flags and ninth bit follow head entry
            if (countNxt == 2'h0)
            begin
                serialDataReg <= 8'h00;
                {framingErrorFlag, parityErrorFlag, dataOverrunFlag,
                    receivedNinthBit} <= 4'h0;
            end
            else if (count_r == 2'h0 || pop)
            begin
                serialDataReg <= shown[7:0];
                receivedNinthBit <= shown[8];
                framingErrorFlag <= shown[11];
                parityErrorFlag <= shown[10];
                dataOverrunFlag <= shown[9];
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/usfrb_usart_chk.sv
// port assertions for the serial frame block
`default_nettype none
module usfrb_usart_chk #(
    parameter [15:0] BIT_DIV = 16'h0004
) (
    // clock, reset, controls
    input wire logic clk,
    input wire logic rst_n,
    input wire logic syncMode,
    input wire logic syncClockPolarity,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic dataRead,
    input wire logic rxValid,
    // serial lines
    input wire logic txdPin,
    input wire logic syncSerialClock
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMAX = 2 * BIT_DIV + 2;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    idle_line_high_a: assert property (txReady |-> txdPin)
        else $error("line low at idle");
    start_bit_low_a: assert property (txValid && txReady && !syncMode
        |=> !txReady ##[0:TMAX] !txdPin) else $error("no start bit");
    last_stop_high_a: assert property ($rose(txReady) && !syncMode
        |-> txdPin[*4]) else $error("stop bit low");
    bit_hold_a: assert property (!syncMode && $changed(txdPin)
        |=> $stable(txdPin)[*3]) else $error("bit too short");
    change_on_fall_a: assert property (syncMode && !syncClockPolarity
        && $changed(txdPin) |-> !syncSerialClock) else $error("pol0 edge");
    change_on_rise_a: assert property (syncMode && syncClockPolarity
        && $changed(txdPin) |-> syncSerialClock) else $error("pol1 edge");
    empty_read_a: assert property (!rxValid && dataRead
        |=> !rxValid) else $error("empty read popped");
    buffer_pop_a: assert property ($fell(rxValid)
        |-> $past(dataRead) || $past(dataRead, 2)) else $error("lost entry");
    cover property (txValid && txReady && syncMode);
    cover property (dataRead && rxValid);
    cover property ($rose(rxValid));
endmodule
bind usfrb_usart usfrb_usart_chk #(.BIT_DIV(BIT_DIV)) chk_inst (.clk(clk),
    .rst_n(rst_n), .syncMode(syncMode),
    .syncClockPolarity(syncClockPolarity), .txValid(txValid),
    .txReady(txReady), .dataRead(dataRead), .rxValid(rxValid),
    .txdPin(txdPin), .syncSerialClock(syncSerialClock));
`default_nettype wire

//--- verif/usfrb_remote.sv
// behavioural remote transceiver on the serial lines
`default_nettype none
module usfrb_remote #(
    parameter int DIV = 4
) (
    // bit timing
    input wire logic clk,
    // serial lines
    input wire logic txdPin,
    output logic rxdPin = 1'b1,
    output logic syncSerialClock = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // async frame out, index 0 first
    task automatic send(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxdPin <= b[i];
            repeat (DIV) @(posedge clk);
        end
        rxdPin <= 1'b1;
        @(posedge clk);
    endtask
    // frame capture, sync clock runs only here
    task automatic grab(input logic sy, pl, input int n,
        output logic [15:0] b);
        int i;
        b = 16'h0000;
        i = 0;
        if (sy)
            #7 syncSerialClock = pl;
        for (int k = 0; k < 400 && i < n + 2 * sy; k++)
        begin
            if (sy)
                #160 syncSerialClock = ~pl;
            else
                @(negedge clk);
            if (i > 0 || !txdPin)
            begin
                if (i == 0 && !sy)
                    repeat (DIV / 2) @(negedge clk);
                b[i] = txdPin & (i < n);
                i++;
                if (!sy)
                    repeat (DIV - 1) @(negedge clk);
            end
            if (sy)
                #160 syncSerialClock = pl;
        end
    endtask
endmodule
`default_nettype wire

//--- verif/usfrb_usart_bench.sv
// self-checking bench for the serial frame block
`default_nettype none
module usfrb_usart_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam [15:0] DIV = 16'h0004;
    logic clk = 1'b0, rst_n = 1'b0, syncMode = 1'b0, pol = 1'b0;
    logic two = 1'b0, txValid = 1'b0, dataRead = 1'b0;
    logic [2:0] size = 3'h3;
    logic [1:0] par = 2'h0;
    logic [8:0] txData = 9'h000;
    wire logic txReady, rxValid, n9, fe, data_overrun_flag, pe, txd, rxd, sclk;
    wire logic [7:0] rxData;
    int bad_count = 0, checks = 0;
    always #20 clk = ~clk;
    usfrb_usart #(.BIT_DIV(DIV)) usfrb_usart_inst (.clk(clk), .rst_n(rst_n),
        .syncMode(syncMode), .syncClockPolarity(pol),
        .characterSizeCode(size), .parityMode(par), .twoStopBits(two),
        .txValid(txValid), .txData(txData), .txReady(txReady),
        .dataRead(dataRead), .rxValid(rxValid), .serialDataReg(rxData),
        .receivedNinthBit(n9), .framingErrorFlag(fe), .dataOverrunFlag(data_overrun_flag),
        .parityErrorFlag(pe), .rxdPin(rxd), .syncSerialClock(sclk),
        .txdPin(txd));
    usfrb_remote #(.DIV(DIV)) usfrb_remote_inst (.clk(clk), .txdPin(txd),
        .rxdPin(rxd), .syncSerialClock(sclk));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic report_and_stop(input int hung);
        bad_count += hung;
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic waitHi(input bit rx);
        for (int k = 0; k < 300; k++)
        begin
            @(posedge clk);
            if ((rx ? rxValid : txReady) === 1'b1)
                return;
        end
        report_and_stop(1);
    endtask
    // expected line bits, first bit at index 0
    function automatic logic [15:0] mk(input logic [8:0] d, output int n);
        int nb;
        nb = (size == 3'h7) ? 9 : size + 5;
        mk = 16'h0000;
        for (int i = 0; i < nb; i++)
            mk[i + 1] = d[i];
        n = nb + 1;
        if (par[1])
            mk[n] = ^(d & 9'((16'h1 << nb) - 1)) ^ par[0];
        n = n + par[1];
        mk[n] = 1'b1;
        mk[n + 1] = two;
        n = n + 1 + two;
    endfunction
    task automatic tx(input logic [8:0] d);
        txValid <= 1'b1;
        txData <= d;
        waitHi(0);
        txValid <= 1'b0;
    endtask
    task automatic txFormats;
        logic [15:0] got, e;
        int n;
        for (int f = 0; f < 32; f++)
        begin
            size <= (f % 5 == 4) ? 3'h7 : 3'(f % 5);
            par <= (f / 5 % 3 == 0) ? 2'h0 : 2'(f / 5 % 3 + 1);
            two <= f / 15 == 1;
            syncMode <= f > 29;
            pol <= f[0];
            @(posedge clk);
            e = mk(9'(f * 37 + 5), n);
            fork
                usfrb_remote_inst.grab(syncMode, pol, n, got);
                tx(9'(f * 37 + 5));
            join
            repeat (DIV) @(posedge clk);
            chk("frame", e, got);
            chk("idle", 16'h3, {14'h0, txReady, txd});
        end
        syncMode <= 1'b0;
    endtask
    task automatic snd(input logic [8:0] d, input int flip);
        logic [15:0] e;
        int n;
        e = mk(d, n);
        e[flip] = ~e[flip];
        usfrb_remote_inst.send(e, n);
    endtask
    task automatic rd(input logic [8:0] d, input logic [2:0] f);
        waitHi(1);
        chk("flags", {13'h0, f}, {13'h0, fe, data_overrun_flag, pe});
        chk("data", {7'h0, d}, {7'h0, n9, rxData});
        dataRead <= 1'b1;
        @(posedge clk);
        dataRead <= 1'b0;
        @(posedge clk);
    endtask
    // fill, drop, read in order, errors, ninth bit, empty read
    task automatic rxScen;
        par <= 2'h2;
        size <= 3'h3;
        @(posedge clk);
        snd(9'h03c, 15);
        snd(9'h0b5, 9);
        snd(9'h011, 15);
        rd(9'h03c, 3'h0);
        rd(9'h0b5, 3'h1);
        snd(9'h081, 10);
        rd(9'h081, 3'h6);
        size <= 3'h7;
        @(posedge clk);
        snd(9'h1c3, 15);
        rd(9'h1c3, 3'h0);
        dataRead <= 1'b1;
        @(posedge clk);
        dataRead <= 1'b0;
        repeat (2) @(posedge clk);
        chk("empty", 16'h0, {15'h0, rxValid});
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        txFormats;
        rxScen;
        report_and_stop(0);
    end
endmodule
`default_nettype wire
